// >>> src/rps_pkg.sv
// Package for the remappable pin select block: register map, fields, widths.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
`default_nettype none
package rps_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [3:0] RPS_OFS_INPUT_SEL = 4'h0;
  localparam logic [3:0] RPS_OFS_MAP_113_118 = 4'h4;
  localparam logic [3:0] RPS_OFS_MAP_120_125 = 4'h8;
  localparam int RPS_ADDR_W = 4;
  // ----------------------------------------
  // Field layout and widths
  // ----------------------------------------
  localparam int RPS_OUT_SEL_W = 6;
  localparam int RPS_IN_SEL_W = 7;
  localparam int RPS_HI_LSB = 8;
  localparam int RPS_LO_LSB = 0;
  localparam int RPS_REG_W = 16;
  localparam logic [RPS_IN_SEL_W-1:0] RPS_IN_SEL_GND = 7'h00;
  localparam logic [RPS_IN_SEL_W-1:0] RPS_IN_SEL_COMPARATOR_ONE_OUTPUT = 7'h01;
  localparam int RPS_REMAP_IN_N = 128;
  localparam int RPS_FUNC_N = 64;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [RPS_OUT_SEL_W-1:0] RPS_OUT_RST = 6'h00;
  localparam logic [RPS_IN_SEL_W-1:0] RPS_IN_RST = 7'h00;
  localparam logic [31:0] RPS_RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [RPS_IN_SEL_W-1:0] clk_sel;
    logic [RPS_IN_SEL_W-1:0] dat_sel;
  } rps_in_sel_t;

  typedef struct packed {
    logic [RPS_OUT_SEL_W-1:0] pin118;
    logic [RPS_OUT_SEL_W-1:0] pin113;
    logic [RPS_OUT_SEL_W-1:0] pin125;
    logic [RPS_OUT_SEL_W-1:0] pin120;
  } rps_out_sel_t;

  typedef struct packed {
    rps_in_sel_t in_sel;
    rps_out_sel_t out_sel;
    logic [31:0] rdata;
    logic rvalid;
  } rps_state_t;
endpackage : rps_pkg
`default_nettype wire

// >>> src/rps_top.sv
// Remappable pin select: input routing for serial port 2, output function muxes.
// Assumes an Avalon-MM master on sys_clk_i; pins and functions synchronous.
`default_nettype none
module rps_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [rps_pkg::RPS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Input routing sources
  input wire logic [rps_pkg::RPS_REMAP_IN_N-1:0] remap_pin_i,
  input wire logic comparator_one_output_i,
  // Routed serial port 2 inputs
  output logic serial2_clock_o,
  output logic serial2_data_o,
  // Peripheral output functions and remapped pins
  input wire logic [rps_pkg::RPS_FUNC_N-1:0] periph_func_i,
  output logic pin113_o,
  output logic pin118_o,
  output logic pin120_o,
  output logic pin125_o
);
  rps_pkg::rps_state_t state_reg;
  rps_pkg::rps_state_t state_next;
  logic acc;
  logic [15:0] rd_mux;

  // ----------------------------------------
  // Bus: one wait cycle, answer on second edge
  // ----------------------------------------
  assign acc = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = acc & ~state_reg.rvalid;
  assign avs_readdata_o = state_reg.rdata;

  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (avs_address_i)
      rps_pkg::RPS_OFS_INPUT_SEL:
        rd_mux = {1'b0, state_reg.in_sel.clk_sel, 1'b0, state_reg.in_sel.dat_sel};
      rps_pkg::RPS_OFS_MAP_113_118:
        rd_mux = {2'b00, state_reg.out_sel.pin118, 2'b00, state_reg.out_sel.pin113};
      rps_pkg::RPS_OFS_MAP_120_125:
        rd_mux = {2'b00, state_reg.out_sel.pin125, 2'b00, state_reg.out_sel.pin120};
      default:
        rd_mux = 16'h0000;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = acc & ~state_reg.rvalid;
    if (avs_read_i & ~state_reg.rvalid)
    begin
      state_next.rdata = {16'h0000, rd_mux};
    end
    // Write lands on the edge that completes the transfer
    if (avs_write_i & state_reg.rvalid)
    begin
      unique case (avs_address_i)
        rps_pkg::RPS_OFS_INPUT_SEL:
        begin
          if (avs_byteenable_i[1])
          begin
            state_next.in_sel.clk_sel = avs_writedata_i[14:8];
          end
          if (avs_byteenable_i[0])
          begin
            state_next.in_sel.dat_sel = avs_writedata_i[6:0];
          end
        end
        rps_pkg::RPS_OFS_MAP_113_118:
        begin
          if (avs_byteenable_i[1])
          begin
            state_next.out_sel.pin118 = avs_writedata_i[13:8];
          end
          if (avs_byteenable_i[0])
          begin
            state_next.out_sel.pin113 = avs_writedata_i[5:0];
          end
        end
        rps_pkg::RPS_OFS_MAP_120_125:
        begin
          if (avs_byteenable_i[1])
          begin
            state_next.out_sel.pin125 = avs_writedata_i[13:8];
          end
          if (avs_byteenable_i[0])
          begin
            state_next.out_sel.pin120 = avs_writedata_i[5:0];
          end
        end
        default:
        begin
          state_next.rdata = state_reg.rdata;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg.in_sel.clk_sel <= rps_pkg::RPS_IN_RST;
      state_reg.in_sel.dat_sel <= rps_pkg::RPS_IN_RST;
      state_reg.out_sel.pin118 <= rps_pkg::RPS_OUT_RST;
      state_reg.out_sel.pin113 <= rps_pkg::RPS_OUT_RST;
      state_reg.out_sel.pin125 <= rps_pkg::RPS_OUT_RST;
      state_reg.out_sel.pin120 <= rps_pkg::RPS_OUT_RST;
      state_reg.rdata <= rps_pkg::RPS_RD_ZERO;
      state_reg.rvalid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Routing
  // ----------------------------------------
  function automatic logic route_in(input logic [rps_pkg::RPS_IN_SEL_W-1:0] sel,
                                    input logic cmp,
                                    input logic [rps_pkg::RPS_REMAP_IN_N-1:0] pins);
    logic r;
    r = pins[sel];
    if (sel == rps_pkg::RPS_IN_SEL_GND)
    begin
      r = 1'b0;
    end
    else if (sel == rps_pkg::RPS_IN_SEL_COMPARATOR_ONE_OUTPUT)
    begin
      r = cmp;
    end
    return r;
  endfunction : route_in

  assign serial2_clock_o = route_in(state_reg.in_sel.clk_sel, comparator_one_output_i,
                                    remap_pin_i);
  assign serial2_data_o = route_in(state_reg.in_sel.dat_sel, comparator_one_output_i,
                                   remap_pin_i);
  assign pin118_o = periph_func_i[state_reg.out_sel.pin118];
  assign pin113_o = periph_func_i[state_reg.out_sel.pin113];
  assign pin125_o = periph_func_i[state_reg.out_sel.pin125];
  assign pin120_o = periph_func_i[state_reg.out_sel.pin120];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence wr_map_lo_s;
    avs_write_i && !avs_waitrequest_o && avs_address_i == rps_pkg::RPS_OFS_MAP_113_118;
  endsequence

  sequence wr_map_hi_s;
    avs_write_i && !avs_waitrequest_o && avs_address_i == rps_pkg::RPS_OFS_MAP_120_125;
  endsequence

  sequence wr_in_sel_s;
    avs_write_i && !avs_waitrequest_o && avs_address_i == rps_pkg::RPS_OFS_INPUT_SEL;
  endsequence

  sequence rd_done_s;
    $rose(state_reg.rvalid) && $past(avs_read_i);
  endsequence

  pin118_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_map_lo_s ##0 avs_byteenable_i[1] |=>
    pin118_o == periph_func_i[$past(avs_writedata_i[13:8])])
    else $error("pin 118 function not taken from write");
  pin113_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_map_lo_s ##0 avs_byteenable_i[0] |=> state_reg.out_sel.pin113 == $past(avs_writedata_i[5:0]))
    else $error("pin 113 select not updated");
  pin125_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_map_hi_s ##0 avs_byteenable_i[1] |=>
    state_reg.out_sel.pin125 == $past(avs_writedata_i[13:8]))
    else $error("pin 125 select not updated");
  pin120_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_map_hi_s ##0 avs_byteenable_i[0] |=>
    pin120_o == periph_func_i[$past(avs_writedata_i[5:0])])
    else $error("pin 120 function not taken from write");
  unused_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_done_s ##0 $past(avs_address_i) != rps_pkg::RPS_OFS_INPUT_SEL |->
    avs_readdata_o[15:14] == 2'b00 && avs_readdata_o[7:6] == 2'b00)
    else $error("unused map bits read nonzero");
  in_pad_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_done_s ##0 $past(avs_address_i) == rps_pkg::RPS_OFS_INPUT_SEL |->
    !avs_readdata_o[15] && !avs_readdata_o[7])
    else $error("unused input select bits read nonzero");
  gnd_input_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.in_sel.clk_sel == rps_pkg::RPS_IN_SEL_GND |-> !serial2_clock_o)
    else $error("clock input not tied low");
  cmp_input_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.in_sel.dat_sel == rps_pkg::RPS_IN_SEL_COMPARATOR_ONE_OUTPUT |->
    serial2_data_o == comparator_one_output_i)
    else $error("data input not from comparator");
  remap_clock_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_in_sel_s ##0 avs_byteenable_i[1] && avs_writedata_i[14:8] > rps_pkg::RPS_IN_SEL_COMPARATOR_ONE_OUTPUT |=>
    serial2_clock_o == remap_pin_i[$past(avs_writedata_i[14:8])])
    else $error("clock input not taken from selected pin");
  remap_data_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_in_sel_s ##0 avs_byteenable_i[0] && avs_writedata_i[6:0] > rps_pkg::RPS_IN_SEL_COMPARATOR_ONE_OUTPUT |=>
    serial2_data_o == remap_pin_i[$past(avs_writedata_i[6:0])])
    else $error("data input not taken from selected pin");
  bus_answer_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule : rps_top
`default_nettype wire

// >>> test/tb.sv
// Bench for the remappable pin select block: bus master, model, checks.
// Assumes rps_pkg and rps_top are compiled first; one 200 MHz clock.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [127:0] remap_pin_i = '0;
  logic comparator_one_output_i = 1'b0;
  logic [63:0] periph_func_i = '0;
  logic serial2_clock_o;
  logic serial2_data_o;
  logic pin113_o;
  logic pin118_o;
  logic pin120_o;
  logic pin125_o;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h0000_F2AB;
  logic [15:0] model [4] = '{default: 16'h0000};

  always #2.5 sys_clk_i = ~sys_clk_i;

  rps_top u_rps_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .remap_pin_i(remap_pin_i),
    .comparator_one_output_i(comparator_one_output_i), .serial2_clock_o(serial2_clock_o),
    .serial2_data_o(serial2_data_o), .periph_func_i(periph_func_i), .pin113_o(pin113_o),
    .pin118_o(pin118_o), .pin120_o(pin120_o), .pin125_o(pin125_o));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  function automatic logic in_route(input logic [6:0] v);
    if (v == 7'h00) return 1'b0;
    if (v == 7'h01) return comparator_one_output_i;
    return remap_pin_i[v];
  endfunction : in_route

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0)
    begin
      fail_count++;
      finish_test();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic check_pins;
    check("serial2_clock", {31'h0, serial2_clock_o}, {31'h0, in_route(model[0][14:8])});
    check("serial2_data", {31'h0, serial2_data_o}, {31'h0, in_route(model[0][6:0])});
    check("pin118", {31'h0, pin118_o}, {31'h0, periph_func_i[model[1][13:8]]});
    check("pin113", {31'h0, pin113_o}, {31'h0, periph_func_i[model[1][5:0]]});
    check("pin125", {31'h0, pin125_o}, {31'h0, periph_func_i[model[2][13:8]]});
    check("pin120", {31'h0, pin120_o}, {31'h0, periph_func_i[model[2][5:0]]});
  endtask : check_pins

  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    logic [31:0] q;
    logic [31:0] wd;
    logic [3:0] be;
    logic [15:0] m;
    int idx;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 52; i++)
    begin
      seed = xorshift(seed);
      idx = (i < 4) ? i : (i < 6) ? 0 : int'(seed[3:2]);
      wd = xorshift(seed);
      seed = xorshift(wd);
      be = (i < 4) ? 4'h0 : seed[7:4];
      if (i >= 4 && i < 6)
      begin
        wd[14:8] = 7'(i - 4);
        wd[6:0] = 7'(i - 4);
        be = 4'hF;
      end
      m = (idx == 0) ? 16'h7F7F : (idx == 3) ? 16'h0000 : 16'h3F3F;
      m = m & {{8{be[1]}}, {8{be[0]}}};
      bus(1'b0, 4'(idx * 4), wd, be, q);
      model[idx] = (model[idx] & ~m) | (wd[15:0] & m);
      bus(1'b1, 4'(idx * 4), 32'h0000_0000, 4'hF, q);
      check("readback", q, {16'h0000, model[idx]});
      remap_pin_i <= {remap_pin_i[95:0], seed};
      periph_func_i <= {periph_func_i[31:0], ~seed};
      comparator_one_output_i <= seed[9];
      @(negedge sys_clk_i);
      check_pins();
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
